/* src/hcc_top.sv */
// Purpose: per-frame hop scheduling and cipher mode control, AXI4-Lite registers
// Assumes: all inputs from logic on aclk; one frame_tick pulse per TDMA frame
// Notes: nunit at most 8; one shared frequency list
//
// Overview of operation
// - carrier of hopping unit changes per frame
// - baseband: burst routed to varying transmitter
// - synthesizer: own transmitter retuned each burst
// - activation starts hopping, channel id ignored
// - per-unit parameters kept, untouched at activation
// - broadcast control unit never hops
// - baseband lets broadcast-carrier units hop
// - selector zero cyclic, 1-63 pseudo-random
// - per-unit offset added to frame index
// - list holds one to sixty-four carriers
// - activation ciphers only with encryption element
// - encryption refused on immediate assignment
// - handover access burst never deciphered
// - ciphering on traffic, sdcch8, sdcch4 slot zero
// - activation cipher start ends at acknowledge
// - encryption command: decipher now, command mobile
// - mode complete: encipher, data indication upward
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "hcc_map.svh"
module hcc_top #(
   parameter int NUNIT = 8,
   parameter int ARFCN_W = 10
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic frame_tick,
   input wire logic burst_valid,
   input wire logic [2:0] burst_unit,
   input wire logic burst_access,
   output logic burst_valid_q,
   output logic [ARFCN_W-1:0] burst_arfcn_q,
   output logic [2:0] burst_tx_q,
   output logic burst_decipher_q,
   output logic burst_encipher_q,
   input wire logic act_valid,
   input wire logic [2:0] act_unit,
   input wire hcc_pkg::hcc_act_t act_type,
   input wire logic act_enc,
   input wire hcc_pkg::hcc_chan_t act_chan,
   input wire logic [2:0] act_ts,
   input wire logic [7:0] act_chan_id,
   input wire logic rel_valid,
   input wire logic [2:0] rel_unit,
   input wire logic enc_cmd_valid,
   input wire logic [2:0] enc_cmd_unit,
   input wire logic ms_done_valid,
   input wire logic [2:0] ms_done_unit,
   output logic act_ack_q,
   output logic [2:0] act_ack_unit_q,
   output logic act_ack_enc_q,
   output logic cm_cmd_q,
   output logic [2:0] cm_cmd_unit_q,
   output logic data_ind_q,
   output logic [2:0] data_ind_unit_q
);
   localparam int UW = 3;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q, wdat_q;
   logic [7:0] awaddr_q;
   logic [3:0] wstrb_q;
   logic aw_held_q, w_held_q;
   logic [UW-1:0] unit_sel_q;
   logic [19:0] cfg_q [NUNIT];
   logic [5:0] len_q;
   logic [5:0] ptr_q;
   logic [ARFCN_W-1:0] list_q [64];
   logic [NUNIT-1:0] act_q, deciph_q, enciph_q, pend_q, cok_q;
   logic [5:0] cnt_q [NUNIT];
   logic [5:0] lfsr_q [NUNIT];
   logic [5:0] mai_q [NUNIT];
   logic [5:0] cnt_d [NUNIT];
   logic [5:0] lfsr_d [NUNIT];
   logic [5:0] mai_d [NUNIT];
   logic [NUNIT-1:0] hopping;

   // sequence arithmetic: index reduced modulo list length
   function automatic logic [6:0] hcc_mod(input logic [6:0] v, input logic [6:0] n);
      logic [12:0] r;
      r = {6'h00, v};
      for (int i = 6; i >= 0; i--)
      begin
         if (r >= ({6'h00, n} << i))
            r = r - ({6'h00, n} << i);
      end
      return r[6:0];
   endfunction

   wire [6:0] hop_n = {1'b0, len_q} + 7'h01;
   wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
   wire rd_fire = arvalid && arready_q;
   wire [31:0] status_w;
   wire [19:0] sel_cfg = cfg_q[unit_sel_q];
   wire [5:0] sel_mai = mai_q[unit_sel_q];
   wire [31:0] unit_idx_w = {6'h00, list_q[sel_mai], 10'h000, sel_mai};

   genvar g;
   for (g = 0; g < 8; g++)
   begin : g_stat
      if (g < NUNIT)
      begin : g_on
         assign status_w[g] = act_q[g];
         assign status_w[8 + g] = deciph_q[g];
         assign status_w[16 + g] = enciph_q[g];
         assign status_w[24 + g] = pend_q[g];
      end
      else
      begin : g_off
         assign status_w[g] = 1'b0;
         assign status_w[8 + g] = 1'b0;
         assign status_w[16 + g] = 1'b0;
         assign status_w[24 + g] = 1'b0;
      end
   end

   function automatic logic [32:0] hcc_rmux(input logic [7:0] a);
      logic [32:0] r;
      r = {1'b1, 32'h0};
      unique case (a)
         `HCC_OFF_STATUS: r = {1'b0, status_w};
         `HCC_OFF_UNIT_SEL: r = {1'b0, 29'h0, unit_sel_q};
         `HCC_OFF_UNIT_CFG: r = {1'b0, 12'h000, sel_cfg};
         `HCC_OFF_LIST_LEN: r = {1'b0, 25'h0, hop_n};
         `HCC_OFF_LIST_PTR: r = {1'b0, 26'h0, ptr_q};
         `HCC_OFF_LIST_DATA: r = {1'b0, 22'h0, list_q[ptr_q]};
         `HCC_OFF_UNIT_IDX: r = {1'b0, unit_idx_w};
         default: r = {1'b1, 32'h0};
      endcase
      return r;
   endfunction

   logic [32:0] rd_mux, wr_old;
   // a process, so that state read inside the mux wakes it too
   always_comb
   begin
      rd_mux = hcc_rmux(araddr);
      wr_old = hcc_rmux(awaddr_q);
   end
   wire [31:0] wr_val;
   for (g = 0; g < 4; g++)
   begin : g_strb
      assign wr_val[8*g +: 8] = wstrb_q[g] ? wdat_q[8*g +: 8] : wr_old[8*g +: 8];
   end
   wire wr_err = wr_old[32] || awaddr_q == `HCC_OFF_STATUS || awaddr_q == `HCC_OFF_UNIT_IDX;
   wire wr_ok = wr_fire && !wr_err;
   wire [6:0] len_new = (|wr_val[31:7]) ? 7'h7f : wr_val[6:0];

   // an active unit with hopping enabled hops unless it carries the broadcast channel, or shares its carrier while
   // synthesizer-hopped
   always_comb
   begin
      for (int i = 0; i < NUNIT; i++)
      begin
         hopping[i] = act_q[i] && cfg_q[i][`HCC_CFG_HOPEN_BIT]
            && !cfg_q[i][`HCC_CFG_BCCH_BIT]
            && !(cfg_q[i][`HCC_CFG_MODE_BIT] && cfg_q[i][`HCC_CFG_ONBC_BIT]);
      end
   end

   always_comb
   begin
      logic [6:0] nxt;
      logic [6:0] base;
      logic [5:0] raw;
      nxt = 7'h00;
      base = 7'h00;
      raw = 6'h00;
      for (int i = 0; i < NUNIT; i++)
      begin
         nxt = {1'b0, cnt_q[i]} + 7'h01;
         cnt_d[i] = (nxt >= hop_n) ? 6'h00 : nxt[5:0];
         lfsr_d[i] = {lfsr_q[i][4:0], lfsr_q[i][5] ^ lfsr_q[i][4]};
         // selector zero walks the list in order, else pseudo-random
         raw = (cfg_q[i][5:0] == 6'h00) ? cnt_d[i] : lfsr_d[i];
         nxt = hcc_mod({1'b0, raw} + {1'b0, cfg_q[i][13:8]}, hop_n);
         base = hcc_mod({1'b0, cfg_q[i][13:8]}, hop_n);
         mai_d[i] = hopping[i] ? nxt[5:0] : base[5:0];
      end
   end

   wire cipher_ok = act_enc && act_type != hcc_pkg::HCC_ACT_IMMEDIATE;
   wire chan_ok = act_chan != hcc_pkg::HCC_CH_SDCCH4 || act_ts == 3'h0;
   wire [5:0] act_hsn = cfg_q[act_unit][5:0];
   wire enc_go = enc_cmd_valid && act_q[enc_cmd_unit] && cok_q[enc_cmd_unit];
   wire done_go = ms_done_valid && pend_q[ms_done_unit];
   wire [5:0] b_mai = mai_q[burst_unit];
   wire b_synth = cfg_q[burst_unit][`HCC_CFG_MODE_BIT];
   wire [6:0] act_base = hcc_mod({1'b0, cfg_q[act_unit][13:8]}, hop_n);
   wire [6:0] base0 = hcc_mod({1'b0, cfg_q[0][13:8]}, hop_n);

   // axi slave: address and data taken in either order, answer after both
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdat_q <= 32'h0;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `HCC_RESP_OKAY;
      end
      else if (ce)
      begin
         if (awvalid && awready_q)
         begin
            awaddr_q <= awaddr;
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (wvalid && wready_q)
         begin
            wdat_q <= wdata;
            wstrb_q <= wstrb;
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
         end
         if (wr_fire)
         begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_err ? `HCC_RESP_SLVERR : `HCC_RESP_OKAY;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
         end
         if (bvalid_q && bready)
         begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= `HCC_RESP_OKAY;
      end
      else if (ce)
      begin
         if (rd_fire)
         begin
            rvalid_q <= 1'b1;
            arready_q <= 1'b0;
            rdata_q <= rd_mux[31:0];
            rresp_q <= rd_mux[32] ? `HCC_RESP_SLVERR : `HCC_RESP_OKAY;
         end
         else if (rvalid_q && rready)
         begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // configuration; only software writes reach it, activation never does
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         unit_sel_q <= '0;
         len_q <= `HCC_LEN_RST;
         ptr_q <= 6'h00;
         for (int i = 0; i < NUNIT; i++)
            cfg_q[i] <= `HCC_CFG_RST;
         for (int k = 0; k < 64; k++)
            list_q[k] <= '0;
      end
      else if (ce && wr_ok)
      begin
         unique case (awaddr_q)
            `HCC_OFF_UNIT_SEL: unit_sel_q <= wr_val[UW-1:0];
            `HCC_OFF_UNIT_CFG: cfg_q[unit_sel_q] <= wr_val[19:0];
            // lengths outside one to sixty-four are clamped
            `HCC_OFF_LIST_LEN: len_q <= (len_new == 7'h00) ? 6'h00 :
               (len_new >= `HCC_MAX_FREQ) ? 6'h3f : 6'(len_new - 7'h01);
            `HCC_OFF_LIST_PTR: ptr_q <= wr_val[5:0];
            `HCC_OFF_LIST_DATA:
            begin
               list_q[ptr_q] <= wr_val[ARFCN_W-1:0];
               ptr_q <= ptr_q + 6'h01;
            end
            default: ptr_q <= ptr_q;
         endcase
      end
   end

   // hop state: loaded at activation, stepped only on frame_tick
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 0; i < NUNIT; i++)
         begin
            cnt_q[i] <= 6'h00;
            lfsr_q[i] <= 6'h01;
            mai_q[i] <= 6'h00;
         end
      end
      else if (ce)
      begin
         if (frame_tick)
         begin
            cnt_q <= cnt_d;
            lfsr_q <= lfsr_d;
            mai_q <= mai_d;
         end
         if (act_valid)
         begin
            cnt_q[act_unit] <= 6'h00;
            lfsr_q[act_unit] <= (act_hsn == 6'h00) ? 6'h01 : act_hsn;
            mai_q[act_unit] <= act_base[5:0];
         end
      end
   end

   // channel and cipher state; release wins over everything else on that unit except cok_q
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         act_q <= '0;
         deciph_q <= '0;
         enciph_q <= '0;
         pend_q <= '0;
         cok_q <= '0;
         act_ack_q <= 1'b0;
         act_ack_unit_q <= 3'h0;
         act_ack_enc_q <= 1'b0;
         cm_cmd_q <= 1'b0;
         cm_cmd_unit_q <= 3'h0;
         data_ind_q <= 1'b0;
         data_ind_unit_q <= 3'h0;
      end
      else if (ce)
      begin
         act_ack_q <= act_valid;
         cm_cmd_q <= enc_go;
         data_ind_q <= done_go;
         if (done_go)
         begin
            enciph_q[ms_done_unit] <= 1'b1;
            pend_q[ms_done_unit] <= 1'b0;
            data_ind_unit_q <= ms_done_unit;
         end
         // a new command in the same cycle keeps the unit waiting
         if (enc_go)
         begin
            deciph_q[enc_cmd_unit] <= 1'b1;
            pend_q[enc_cmd_unit] <= 1'b1;
            cm_cmd_unit_q <= enc_cmd_unit;
         end
         if (act_valid)
         begin
            act_q[act_unit] <= 1'b1;
            cok_q[act_unit] <= chan_ok;
            deciph_q[act_unit] <= cipher_ok && chan_ok;
            enciph_q[act_unit] <= cipher_ok && chan_ok;
            pend_q[act_unit] <= 1'b0;
            act_ack_unit_q <= act_unit;
            act_ack_enc_q <= cipher_ok && chan_ok;
         end
         if (rel_valid)
         begin
            act_q[rel_unit] <= 1'b0;
            deciph_q[rel_unit] <= 1'b0;
            enciph_q[rel_unit] <= 1'b0;
            pend_q[rel_unit] <= 1'b0;
         end
      end
   end

   // burst routing: baseband picks transmitter by index, synthesizer retunes own one
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         burst_valid_q <= 1'b0;
         burst_arfcn_q <= '0;
         burst_tx_q <= 3'h0;
         burst_decipher_q <= 1'b0;
         burst_encipher_q <= 1'b0;
      end
      else if (ce)
      begin
         burst_valid_q <= burst_valid;
         burst_arfcn_q <= list_q[b_mai];
         burst_tx_q <= b_synth ? burst_unit : b_mai[2:0];
         burst_decipher_q <= deciph_q[burst_unit] && !burst_access;
         burst_encipher_q <= enciph_q[burst_unit];
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   frame_only_a: assert property (ce && !frame_tick && !act_valid |=> $stable(mai_q[0]))
      else $error("index moved off frame boundary");
   bcch_fixed_a: assert property (ce && frame_tick && !act_valid && cfg_q[0][`HCC_CFG_BCCH_BIT]
      |=> mai_q[0] == base0[5:0])
      else $error("broadcast unit hopped");
   cyc_step_a: assert property (ce && frame_tick && !act_valid && hopping[0]
      && cfg_q[0][5:0] == 6'h00 && cfg_q[0][13:8] == 6'h00 && !wr_ok
      |=> mai_q[0] == cnt_q[0])
      else $error("cyclic index wrong");
   imm_nociph_a: assert property (ce && act_valid && act_type == hcc_pkg::HCC_ACT_IMMEDIATE
      && !rel_valid |=> !deciph_q[$past(act_unit)] && act_ack_q && !act_ack_enc_q)
      else $error("immediate assign ciphered");
   sd4_slot_a: assert property (ce && act_valid && act_chan == hcc_pkg::HCC_CH_SDCCH4
      && act_ts != 3'h0 |=> !act_ack_enc_q)
      else $error("sdcch4 off slot zero ciphered");
   access_clear_a: assert property (ce && burst_valid && burst_access |=> !burst_decipher_q)
      else $error("access burst deciphered");
   enc_cmd_a: assert property (ce && enc_go && !rel_valid && !act_valid
      |=> cm_cmd_q && deciph_q[cm_cmd_unit_q] ##1 !cm_cmd_q || $past(enc_go))
      else $error("encryption command not served");
   done_ind_a: assert property (ce && done_go && !rel_valid && !act_valid && !enc_go
      |=> data_ind_q && enciph_q[data_ind_unit_q] && !pend_q[data_ind_unit_q])
      else $error("mode complete not served");
   ack_once_a: assert property (ce && act_valid |=> act_ack_q && act_ack_unit_q == $past(act_unit))
      else $error("activation not acknowledged");
   len_range_a: assert property (hop_n >= 7'h01 && hop_n <= `HCC_MAX_FREQ)
      else $error("list length out of range");
   idx_range_a: assert property ({1'b0, mai_q[0]} < hop_n || $past(wr_ok, 1) || $past(wr_ok, 2))
      else $error("index beyond list");
   resp_hold_a: assert property (bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
      else $error("write response dropped");

   act_seen_c: cover property (ce && act_valid && cipher_ok && chan_ok);
   cm_flow_c: cover property (cm_cmd_q ##[1:50] data_ind_q);
   hop_rand_c: cover property (ce && frame_tick && hopping[0] && cfg_q[0][5:0] != 6'h00);
   wr_rd_c: cover property (bvalid_q && bready ##[1:10] rvalid_q && rready);
endmodule

/* inc/hcc_map.svh */
// Purpose: register offsets, field positions, reset values of hop and cipher control
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: definitions only
`ifndef HCC_MAP_SVH
`define HCC_MAP_SVH
`define HCC_OFF_STATUS 8'h00
`define HCC_OFF_UNIT_SEL 8'h04
`define HCC_OFF_UNIT_CFG 8'h08
`define HCC_OFF_LIST_LEN 8'h0c
`define HCC_OFF_LIST_PTR 8'h10
`define HCC_OFF_LIST_DATA 8'h14
`define HCC_OFF_UNIT_IDX 8'h18
`define HCC_CFG_HSN_LSB 0
`define HCC_CFG_ALLOC_INDEX_OFFSET_LSB 8
`define HCC_CFG_MODE_BIT 16
`define HCC_CFG_BCCH_BIT 17
`define HCC_CFG_ONBC_BIT 18
`define HCC_CFG_HOPEN_BIT 19
`define HCC_CFG_RST 20'h00000
`define HCC_LEN_RST 6'h00
`define HCC_MAX_FREQ 7'h40
`define HCC_RESP_OKAY 2'h0
`define HCC_RESP_SLVERR 2'h2
`endif

/* inc/hcc_pkg.sv */
// Purpose: types of hop and cipher control
// Assumes: nothing
// Notes: offsets live in hcc_map.svh
package hcc_pkg;
   typedef enum logic [2:0] {
      HCC_ACT_IMMEDIATE = 3'h0,
      HCC_ACT_NORMAL = 3'h1,
      HCC_ACT_ASYNC_HO = 3'h2,
      HCC_ACT_SYNC_HO = 3'h3,
      HCC_ACT_MULTISLOT = 3'h4
   } hcc_act_t;
   typedef enum logic [1:0] {
      HCC_CH_TCH_F = 2'h0,
      HCC_CH_TCH_H = 2'h1,
      HCC_CH_SDCCH8 = 2'h2,
      HCC_CH_SDCCH4 = 2'h3
   } hcc_chan_t;
   typedef enum logic {
      HCC_HOP_BASEBAND = 1'b0,
      HCC_HOP_SYNTH = 1'b1
   } hcc_hop_t;
endpackage

/* tb/hcc_ms_model.sv */
// Purpose: mobile side of the ciphering handshake
// Assumes: dly set by the bench, stable while a command is pending
// Notes: unit line shows the inverse of its last value once released
`timescale 1ns/100ps
module hcc_ms_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cm_cmd_q,
   input wire logic [2:0] cm_cmd_unit_q,
   input wire logic [3:0] dly,
   output logic ms_done_valid,
   output logic [2:0] ms_done_unit
);
   logic pend_q;
   logic [3:0] cnt_q;
   logic [2:0] unit_q;
   always @(posedge aclk)
   begin
      ms_done_valid <= 1'b0;
      if (ms_done_valid)
         ms_done_unit <= ~ms_done_unit;
      if (!aresetn)
         pend_q <= 1'b0;
      else if (cm_cmd_q)
      begin
         pend_q <= 1'b1;
         cnt_q <= dly;
         unit_q <= cm_cmd_unit_q;
      end
      else if (pend_q && cnt_q == 4'h0)
      begin
         ms_done_valid <= 1'b1;
         ms_done_unit <= unit_q;
         pend_q <= 1'b0;
      end
      else if (pend_q)
         cnt_q <= cnt_q - 4'h1;
   end
endmodule

/* tb/tb.sv */
// Purpose: self-checking bench of hop and cipher control
// Assumes: design answers per its hand-over timing
// Notes: activation cases run from a table, the rest by hand
`timescale 1ns/100ps
`include "hcc_map.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb;
   typedef struct packed {
      hcc_pkg::hcc_act_t t;
      hcc_pkg::hcc_chan_t c;
      logic [2:0] ts;
      logic e;
      logic x;
   } hcc_row_t;
   // type, channel, slot, element present, acknowledged with ciphering
   hcc_row_t rows [7] = '{10'h083, 10'h123, 10'h1cf, 10'h263, 10'h002, 10'h0e6, 10'h080};
   logic [31:0] cfg [4] = '{32'h000a0200, 32'h00080100, 32'h000c0001, 32'h00090300};
   int moff [4] = '{2, 1, 0, 3};
   int hop [4] = '{0, 1, 1, 1};
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr, act_chan_id;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic frame_tick, burst_valid, burst_access, act_valid, act_enc, rel_valid, enc_cmd_valid;
   logic burst_valid_q, burst_decipher_q, burst_encipher_q, ms_done_valid;
   logic act_ack_q, act_ack_enc_q, cm_cmd_q, data_ind_q;
   logic [2:0] burst_unit, act_unit, act_ts, rel_unit, enc_cmd_unit, ms_done_unit;
   logic [2:0] burst_tx_q, act_ack_unit_q, cm_cmd_unit_q, data_ind_unit_q;
   logic [9:0] burst_arfcn_q;
   logic [3:0] ms_dly;
   hcc_pkg::hcc_act_t act_type;
   hcc_pkg::hcc_chan_t act_chan;
   int num_errors, tests_run, e;
   hcc_top DUT (.aclk, .aresetn, .ce(1'b1), .awvalid, .awready, .awaddr, .awprot(3'h0),
      .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready,
      .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .frame_tick, .burst_valid,
      .burst_unit, .burst_access, .burst_valid_q, .burst_arfcn_q, .burst_tx_q,
      .burst_decipher_q, .burst_encipher_q, .act_valid, .act_unit, .act_type, .act_enc,
      .act_chan, .act_ts, .act_chan_id, .rel_valid, .rel_unit, .enc_cmd_valid, .enc_cmd_unit,
      .ms_done_valid, .ms_done_unit, .act_ack_q, .act_ack_unit_q, .act_ack_enc_q, .cm_cmd_q,
      .cm_cmd_unit_q, .data_ind_q, .data_ind_unit_q);
   hcc_ms_model ms (.aclk, .aresetn, .cm_cmd_q, .cm_cmd_unit_q, .dly(ms_dly), .ms_done_valid,
      .ms_done_unit);
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   task automatic complete_run;
      if (num_errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic guard(inout int n);
      n++;
      if (n > 100)
      begin
         num_errors++;
         complete_run;
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic pa, pw, ta, tw;
      n = 0;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      while (pa || pw)
      begin
         @(negedge aclk);
         ta = pa && awready === 1'b1;
         tw = pw && wready === 1'b1;
         @(posedge aclk);
         awvalid <= pa && !ta;
         wvalid <= pw && !tw;
         pa = pa && !ta;
         pw = pw && !tw;
         guard(n);
      end
      bready <= 1'b1;
      while (bvalid !== 1'b1)
      begin
         @(negedge aclk);
         guard(n);
      end
      rs = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      do
      begin
         @(negedge aclk);
         @(posedge aclk);
         guard(n);
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      while (rvalid !== 1'b1)
      begin
         @(negedge aclk);
         guard(n);
      end
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask
   task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] x);
      axr(a);
      `CHK(s, x, rd)
   endtask
   task automatic sel(input int u);
      axw(`HCC_OFF_UNIT_SEL, 32'(u));
   endtask
   task automatic act(input int u, input hcc_row_t r);
      @(posedge aclk);
      act_valid <= 1'b1;
      act_unit <= 3'(u);
      act_type <= r.t;
      act_chan <= r.c;
      act_ts <= r.ts;
      act_enc <= r.e;
      act_chan_id <= ~act_chan_id;
      @(posedge aclk);
      act_valid <= 1'b0;
      @(negedge aclk);
      `CHK("ack", 1'b1, act_ack_q)
      `CHK("ack unit", 3'(u), act_ack_unit_q)
      `CHK("ack cipher", r.x, act_ack_enc_q)
   endtask
   task automatic cmd(input logic [2:0] u);
      @(posedge aclk);
      enc_cmd_valid <= 1'b1;
      enc_cmd_unit <= u;
      @(posedge aclk);
      enc_cmd_valid <= 1'b0;
      @(negedge aclk);
   endtask
   task automatic bq(input int u, input logic acc);
      @(posedge aclk);
      burst_valid <= 1'b1;
      burst_unit <= 3'(u);
      burst_access <= acc;
      @(posedge aclk);
      burst_valid <= 1'b0;
      @(negedge aclk);
      `CHK("burst answer", 1'b1, burst_valid_q)
   endtask
   task automatic wait_ind;
      int n;
      n = 0;
      while (data_ind_q !== 1'b1)
      begin
         @(negedge aclk);
         guard(n);
      end
      `CHK("indication unit", 3'h5, data_ind_unit_q)
   endtask
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, frame_tick, burst_valid} = 8'h00;
      {burst_access, act_valid, act_enc, rel_valid, enc_cmd_valid} = 5'h00;
      {burst_unit, act_unit, act_ts, rel_unit, enc_cmd_unit} = 15'h0;
      {awaddr, araddr, wdata} = 48'h0;
      act_type = hcc_pkg::HCC_ACT_NORMAL;
      act_chan = hcc_pkg::HCC_CH_TCH_F;
      act_chan_id = 8'h5a;
      ms_dly = 4'ha;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rchk("status", `HCC_OFF_STATUS, 32'h0);
      rchk("unit cfg", `HCC_OFF_UNIT_CFG, 32'h0);
      rchk("list len", `HCC_OFF_LIST_LEN, 32'h1);
      axr(8'h1c);
      `CHK("unmapped resp", `HCC_RESP_SLVERR, rs)
      `CHK("unmapped data", 32'h0, rd)
      axw(`HCC_OFF_STATUS, 32'hffffffff);
      `CHK("ro write resp", `HCC_RESP_SLVERR, rs)
      rchk("status", `HCC_OFF_STATUS, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         axw(`HCC_OFF_LIST_LEN, 32'(i * 65));
         rchk("list len", `HCC_OFF_LIST_LEN, (i == 0) ? 32'h1 : 32'h40);
      end
      axw(`HCC_OFF_LIST_LEN, 32'h4);
      axw(`HCC_OFF_LIST_PTR, 32'h0);
      for (int i = 0; i < 4; i++)
         axw(`HCC_OFF_LIST_DATA, 32'h64 + 32'(i));
      for (int u = 0; u < 4; u++)
      begin
         sel(u);
         axw(`HCC_OFF_UNIT_CFG, cfg[u]);
         act(u, 10'h080);
      end
      sel(1);
      rchk("unit cfg", `HCC_OFF_UNIT_CFG, cfg[1]);
      for (int k = 0; k < 5; k++)
      begin
         for (int u = 0; u < 4; u++)
         begin
            // unit 2 pseudo-random: seed 1 steps to 2, 4, 8, 16, taken modulo 4
            e = (u == 2) ? ((k == 1) ? 2 : 0) : (moff[u] + hop[u] * k) % 4;
            sel(u);
            rchk("unit index", `HCC_OFF_UNIT_IDX,
               32'((100 + e) * 65536 + e));
            repeat (2)
            begin
               bq(u, 1'b0);
               `CHK("carrier", 10'(100 + e), burst_arfcn_q)
               `CHK("transmitter", (u == 3) ? 3'h3 : 3'(e), burst_tx_q)
            end
         end
         @(posedge aclk);
         frame_tick <= 1'b1;
         @(posedge aclk);
         frame_tick <= 1'b0;
      end
      for (int i = 0; i < 7; i++)
         act(i, rows[i]);
      bq(0, 1'b1);
      `CHK("access decipher", 1'b0, burst_decipher_q)
      `CHK("encipher", 1'b1, burst_encipher_q)
      bq(0, 1'b0);
      `CHK("decipher", 1'b1, burst_decipher_q)
      axr(`HCC_OFF_STATUS);
      `CHK("status after rows", 32'h000f0f7f, rd)
      @(posedge aclk);
      aresetn <= 1'b0;
      @(posedge aclk);
      aresetn <= 1'b1;
      rchk("status", `HCC_OFF_STATUS, 32'h0);
      act(5, 10'h080);
      cmd(3'h6);
      `CHK("refused command", 1'b0, cm_cmd_q)
      cmd(3'h5);
      `CHK("mode command", 1'b1, cm_cmd_q)
      `CHK("mode command unit", 3'h5, cm_cmd_unit_q)
      rchk("status", `HCC_OFF_STATUS, 32'h20002020);
      wait_ind;
      rchk("status", `HCC_OFF_STATUS, 32'h00202020);
      ms_dly <= 4'h0;
      @(posedge aclk);
      rel_valid <= 1'b1;
      rel_unit <= 3'h5;
      @(posedge aclk);
      rel_valid <= 1'b0;
      rchk("status", `HCC_OFF_STATUS, 32'h0);
      act(5, 10'h080);
      cmd(3'h5);
      wait_ind;
      complete_run;
   end
endmodule
